// [hdl/dpot_regs.svh]
// named constants of the dual pot serial command logic
`ifndef DPOT_REGS_SVH
`define DPOT_REGS_SVH

// instruction opcodes, upper nibble of the instruction byte
`define OP_RD_WIPER          4'h9
`define OP_WR_WIPER          4'ha
`define OP_RD_SLOT           4'hb
`define OP_WR_SLOT           4'hc
`define OP_SLOT_TO_WIPER     4'hd
`define OP_WIPER_TO_SLOT     4'he
`define OP_GLB_SLOT_TO_WIPER 4'h1
`define OP_GLB_WIPER_TO_SLOT 4'h8
`define OP_STEP              4'h2
`define OP_RD_STATUS         4'h5

// field positions
`define ID_TYPE_MSB  7
`define ID_TYPE_LSB  4
`define ID_ADDR_MSB  3
`define ID_ADDR_LSB  0
`define INS_OP_MSB   7
`define INS_OP_LSB   4
`define INS_SLOT_MSB 3
`define INS_SLOT_LSB 2
`define INS_POT_BIT  0

// fixed values
`define ADDR_UPPER_FIXED 2'h0
`define DEFAULT_SLOT     2'h0
`define WIPER_TOP        8'hff
`define WIPER_BOTTOM     8'h00
`define BIT_LAST         4'h7
`define BIT_OUT_END      4'h8
`define STATUS_PAD       7'h00

// timing
`define CLK_PERIOD_NS    4
`define NV_WRITE_TIME_US 10000
`define WIPER_SETTLE_NS  40

`endif

// [hdl/dpot_pkg.sv]
// types shared by the dual pot serial command logic
`default_nettype none
package dpot_pkg;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_ID,
      ST_INSTR,
      ST_DATA_IN,
      ST_DATA_OUT,
      ST_STEP,
      ST_IGNORE
   } seq_state_t;

   typedef struct packed {
      logic cs_n;
      logic sck;
      logic si;
      logic hold_n;
   } spi_pins_t;

   typedef struct packed {
      logic dout;
      logic oe;
   } so_pin_t;

   typedef struct packed {
      logic [3:0] op;
      logic [1:0] slot;
      logic spare;
      logic pot;
   } instr_t;

endpackage
`default_nettype wire

// [hdl/wiper_tap_drive.sv]
// settle delay and one-hot tap select for one pot
`default_nettype none
`include "dpot_regs.svh"
module wiper_tap_drive #(
   parameter int unsigned W = 8
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // wiper position
   input wire logic [W-1:0] wiper,
   // tap switches
   output var logic [(1<<W)-1:0] tap_sel
);

   localparam int unsigned SETTLE_CYCLES =
      (`WIPER_SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
   localparam int unsigned CW = $clog2(SETTLE_CYCLES + 1);

   logic [W-1:0] applied_ff;
   logic [CW-1:0] settle_ff;

   // the switch moves once the position has differed from the applied one for the settle time, even if it changed meanwhile
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         applied_ff <= '0;
         settle_ff <= '0;
      end else if (wiper == applied_ff) begin
         settle_ff <= '0;
      end else if (settle_ff == CW'(SETTLE_CYCLES - 1)) begin
         applied_ff <= wiper;
         settle_ff <= '0;
      end else begin
         settle_ff <= settle_ff + CW'(1);
      end
   end

   // registered decode keeps exactly one switch closed
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tap_sel <= {{((1<<W)-1){1'b0}}, 1'b1};
      end else begin
         tap_sel <= '0;
         tap_sel[applied_ff] <= 1'b1;
      end
   end

endmodule
`default_nettype wire

// [hdl/dpot_serial_core.sv]
// serial command interpreter of the dual digitally controlled pot
`default_nettype none
`include "dpot_regs.svh"
// Function
// - write protect low blocks stored setting changes
// - sample serial input on rising clock
// - serial output released when not sending
// - wiper decoded to one of 256 switches
// - power-up loads wiper from default slot
// - four readable writable slots per pot
// - stored setting change finishes within 10ms
// - busy flag high during nonvolatile write
// - first byte type bits must match
// - address bits must match address pins
// - instruction byte: opcode, slot, pot
// - register read/write take three bytes
// - slot-to-wiper copy follows after settle delay
// - wiper-to-slot copy is nonvolatile write
// - global copies act on every pot
// - copy commands end after two bytes
// - step command moves wiper per clock
// - status read returns busy flag
// - output bit changes on falling clock
// - hold pauses sequence, state kept
// - select high deselects, output released
// - ignore traffic until select falls
module dpot_serial_core #(
   parameter int unsigned NV_WRITE_CYCLES = (`NV_WRITE_TIME_US * 1000) / `CLK_PERIOD_NS,
   parameter logic [3:0] TYPE_CODE = 4'ha, // arbitrary value
   parameter logic [7:0] SLOT_INIT = 8'h80,
   parameter int unsigned POTS = 2,
   parameter int unsigned SLOTS = 4,
   parameter int unsigned W = 8
) (
   // clock and reset
   input wire logic clk,
   input wire logic nrst,
   // serial link pins
   input wire dpot_pkg::spi_pins_t spi_pins,
   output var dpot_pkg::so_pin_t so_pin,
   // address and protect pins
   input wire logic addr_pin_hi,
   input wire logic addr_pin_lo,
   input wire logic write_protect_n,
   // status and switches
   output var logic nv_busy,
   output var logic [POTS-1:0][(1<<W)-1:0] tap_sel
);

   localparam int unsigned NW = $clog2(NV_WRITE_CYCLES + 1);
   localparam int unsigned SYNC_W = 7;

   // reset release
   logic [1:0] rst_sync_ff;
   logic rst_n;

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rst_sync_ff <= 2'h0;
      end else begin
         rst_sync_ff <= {rst_sync_ff[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_ff[1];

   // pin synchronisers
   logic [SYNC_W-1:0] pins_raw;
   logic [SYNC_W-1:0] meta_ff;
   logic [SYNC_W-1:0] sync_ff;
   dpot_pkg::spi_pins_t spi_s;
   logic addr_hi_s;
   logic addr_lo_s;
   logic wp_n_s;

   assign pins_raw = {spi_pins, addr_pin_hi, addr_pin_lo, write_protect_n};

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_ff <= '0;
         sync_ff <= '0;
      end else begin
         meta_ff <= pins_raw;
         sync_ff <= meta_ff;
      end
   end

   assign spi_s = dpot_pkg::spi_pins_t'(sync_ff[SYNC_W-1:3]);
   assign addr_hi_s = sync_ff[2];
   assign addr_lo_s = sync_ff[1];
   assign wp_n_s = sync_ff[0];

   // edge finding on the sampled link clock and select
   logic sck_d_ff;
   logic cs_d_ff;
   logic sck_rise;
   logic sck_fall;
   logic cs_fall;

   // select history starts low so a select already low at power-up is no start
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sck_d_ff <= 1'b0;
         cs_d_ff <= 1'b0;
      end else begin
         sck_d_ff <= spi_s.sck;
         cs_d_ff <= spi_s.cs_n;
      end
   end

   // hold only moves while the clock is low, so gating edges is enough to pause
   assign sck_rise = spi_s.sck & ~sck_d_ff & spi_s.hold_n;
   assign sck_fall = ~spi_s.sck & sck_d_ff & spi_s.hold_n;
   assign cs_fall = cs_d_ff & ~spi_s.cs_n;

   // sequence state
   dpot_pkg::seq_state_t state_ff;
   dpot_pkg::seq_state_t nxt_state;
   logic [3:0] bitcnt_ff;
   logic [7:0] shift_ff;
   dpot_pkg::instr_t instr_ff;
   logic [7:0] rx_byte;
   logic shifting;
   dpot_pkg::instr_t ins;
   logic id_ok;
   logic busy_ff;
   logic blocked;
   logic go;
   logic data_done;
   logic step_rise;

   function automatic logic is_read(input logic [3:0] op);
      is_read = (op == `OP_RD_WIPER) || (op == `OP_RD_SLOT) || (op == `OP_RD_STATUS);
   endfunction

   function automatic logic is_nv(input logic [3:0] op);
      is_nv = (op == `OP_WR_SLOT) || (op == `OP_WIPER_TO_SLOT) ||
              (op == `OP_GLB_WIPER_TO_SLOT);
   endfunction

   assign rx_byte = {shift_ff[6:0], spi_s.si};
   assign shifting = (state_ff == dpot_pkg::ST_ID) || (state_ff == dpot_pkg::ST_INSTR) ||
                     (state_ff == dpot_pkg::ST_DATA_IN);
   logic byte_end;
   assign byte_end = shifting & sck_rise & (bitcnt_ff == `BIT_LAST) & ~spi_s.cs_n;
   assign ins = dpot_pkg::instr_t'(rx_byte);
   assign id_ok = (rx_byte[`ID_TYPE_MSB:`ID_TYPE_LSB] == TYPE_CODE) &&
                  (rx_byte[`ID_ADDR_MSB:`ID_ADDR_LSB] ==
                   {`ADDR_UPPER_FIXED, addr_hi_s, addr_lo_s});
   // a running nonvolatile write lets only the status read through
   assign blocked = busy_ff & (ins.op != `OP_RD_STATUS);
   assign go = byte_end & (state_ff == dpot_pkg::ST_INSTR) & ~blocked;
   assign data_done = byte_end & (state_ff == dpot_pkg::ST_DATA_IN);
   assign step_rise = sck_rise & ~spi_s.cs_n & (state_ff == dpot_pkg::ST_STEP);

   always_comb begin
      nxt_state = state_ff;
      unique case (state_ff)
         dpot_pkg::ST_ID: begin
            nxt_state = id_ok ? dpot_pkg::ST_INSTR : dpot_pkg::ST_IGNORE;
         end
         dpot_pkg::ST_INSTR: begin
            if (blocked) begin
               nxt_state = dpot_pkg::ST_IGNORE;
            end else if (is_read(ins.op)) begin
               nxt_state = dpot_pkg::ST_DATA_OUT;
            end else if (ins.op == `OP_WR_WIPER || ins.op == `OP_WR_SLOT) begin
               nxt_state = dpot_pkg::ST_DATA_IN;
            end else if (ins.op == `OP_STEP) begin
               nxt_state = dpot_pkg::ST_STEP;
            end else begin
               nxt_state = dpot_pkg::ST_IGNORE;
            end
         end
         dpot_pkg::ST_DATA_IN: begin
            nxt_state = dpot_pkg::ST_IGNORE;
         end
         dpot_pkg::ST_IDLE, dpot_pkg::ST_DATA_OUT, dpot_pkg::ST_STEP,
         dpot_pkg::ST_IGNORE: begin
            nxt_state = state_ff;
         end
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_ff <= dpot_pkg::ST_IDLE;
         bitcnt_ff <= 4'h0;
         shift_ff <= 8'h00;
         instr_ff <= '0;
      end else if (spi_s.cs_n) begin
         state_ff <= dpot_pkg::ST_IDLE;
         bitcnt_ff <= 4'h0;
      end else if (cs_fall) begin
         state_ff <= dpot_pkg::ST_ID;
         bitcnt_ff <= 4'h0;
      end else if (shifting && sck_rise) begin
         shift_ff <= rx_byte;
         if (byte_end) begin
            bitcnt_ff <= 4'h0;
            state_ff <= nxt_state;
            if (state_ff == dpot_pkg::ST_INSTR) begin
               instr_ff <= ins;
            end
         end else begin
            bitcnt_ff <= bitcnt_ff + 4'h1;
         end
      end else if (state_ff == dpot_pkg::ST_DATA_OUT && sck_fall) begin
         if (bitcnt_ff == `BIT_OUT_END) begin
            state_ff <= dpot_pkg::ST_IGNORE;
         end else begin
            bitcnt_ff <= bitcnt_ff + 4'h1;
         end
      end
   end

   // register storage
   logic [POTS-1:0][W-1:0] wiper_ff;
   logic [POTS-1:0][SLOTS-1:0][W-1:0] slot_ff;
   logic recall_ff;
   logic nv_start;
   logic [NW-1:0] nv_cnt_ff;

   // protect pin low turns every stored setting change into a no-op
   assign nv_start = wp_n_s & ((go & is_nv(ins.op) & (ins.op != `OP_WR_SLOT)) |
                     (data_done & (instr_ff.op == `OP_WR_SLOT)));

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         recall_ff <= 1'b1;
      end else begin
         recall_ff <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wiper_ff <= '0;
      end else begin
         for (int p = 0; p < POTS; p++) begin
            if (recall_ff) begin
               wiper_ff[p] <= slot_ff[p][`DEFAULT_SLOT];
            end else if (go && ins.op == `OP_GLB_SLOT_TO_WIPER) begin
               wiper_ff[p] <= slot_ff[p][ins.slot];
            end else if (go && ins.op == `OP_SLOT_TO_WIPER && ins.pot == 1'(p)) begin
               wiper_ff[p] <= slot_ff[p][ins.slot];
            end else if (data_done && instr_ff.op == `OP_WR_WIPER &&
                         instr_ff.pot == 1'(p)) begin
               wiper_ff[p] <= rx_byte;
            end else if (step_rise && instr_ff.pot == 1'(p)) begin
               if (spi_s.si && wiper_ff[p] != `WIPER_TOP) begin
                  wiper_ff[p] <= wiper_ff[p] + 8'h01;
               end else if (!spi_s.si && wiper_ff[p] != `WIPER_BOTTOM) begin
                  wiper_ff[p] <= wiper_ff[p] - 8'h01;
               end
            end
         end
      end
   end

   // stored slots are flops standing in for the nonvolatile cells
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         slot_ff <= {(POTS*SLOTS){SLOT_INIT}};
      end else if (nv_start) begin
         for (int p = 0; p < POTS; p++) begin
            if (instr_ff.op == `OP_WR_SLOT && state_ff == dpot_pkg::ST_DATA_IN) begin
               if (instr_ff.pot == 1'(p)) begin
                  slot_ff[p][instr_ff.slot] <= rx_byte;
               end
            end else if (ins.op == `OP_GLB_WIPER_TO_SLOT) begin
               slot_ff[p][ins.slot] <= wiper_ff[p];
            end else if (ins.pot == 1'(p)) begin
               slot_ff[p][ins.slot] <= wiper_ff[p];
            end
         end
      end
   end

   // high-voltage write timer, runs on even while deselected
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         nv_cnt_ff <= '0;
         busy_ff <= 1'b0;
      end else if (nv_start) begin
         nv_cnt_ff <= NW'(NV_WRITE_CYCLES);
         busy_ff <= 1'b1;
      end else if (nv_cnt_ff != '0) begin
         nv_cnt_ff <= nv_cnt_ff - NW'(1);
         busy_ff <= (nv_cnt_ff != NW'(1));
      end
   end
   assign nv_busy = busy_ff;

   // read data path
   logic [7:0] rd_data;
   logic [7:0] out_sh_ff;
   logic so_ff;
   logic so_oe_ff;

   always_comb begin
      rd_data = {`STATUS_PAD, busy_ff};
      if (ins.op == `OP_RD_WIPER) begin
         rd_data = wiper_ff[ins.pot];
      end else if (ins.op == `OP_RD_SLOT) begin
         rd_data = slot_ff[ins.pot][ins.slot];
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         out_sh_ff <= 8'h00;
         so_ff <= 1'b0;
         so_oe_ff <= 1'b0;
      end else if (spi_s.cs_n) begin
         so_oe_ff <= 1'b0;
      end else if (go && is_read(ins.op)) begin
         out_sh_ff <= rd_data;
      end else if (state_ff == dpot_pkg::ST_DATA_OUT && sck_fall) begin
         if (bitcnt_ff == `BIT_OUT_END) begin
            so_oe_ff <= 1'b0;
         end else begin
            so_ff <= out_sh_ff[7];
            out_sh_ff <= {out_sh_ff[6:0], 1'b0};
            so_oe_ff <= 1'b1;
         end
      end
   end

   assign so_pin = '{dout: so_ff, oe: so_oe_ff};

   // per-pot settle and switch decode
   generate
      for (genvar g = 0; g < POTS; g++) begin : g_pot
         wiper_tap_drive #(
            .W(W)
         ) u_tap (
            .clk(clk),
            .rst_n(rst_n),
            .wiper(wiper_ff[g]),
            .tap_sel(tap_sel[g])
         );
      end
   endgenerate

endmodule
`default_nettype wire

// [tb/dpot_serial_asserts.sv]
// concurrent checks at the pins of the dual pot serial core
`default_nettype none
module dpot_serial_asserts #(
   parameter int unsigned NV_WRITE_CYCLES = 50
) (
   // clock and reset
   input wire logic clk,
   input wire logic nrst,
   // link pins
   input wire dpot_pkg::spi_pins_t spi_pins,
   input wire dpot_pkg::so_pin_t so_pin,
   // protect, status, switches
   input wire logic write_protect_n,
   input wire logic nv_busy,
   input wire logic [1:0][255:0] tap_sel
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   int unsigned busy_cnt_ff;
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         busy_cnt_ff <= 0;
      end else begin
         busy_cnt_ff <= nv_busy ? busy_cnt_ff + 1 : 0;
      end
   end
   // long enough for the select synchroniser to drain, but shorter than the ten-cycle settle delay
   sequence s_idle8;
      spi_pins.cs_n [*8];
   endsequence
   sequence s_shift;
      so_pin.oe && $past(so_pin.oe) && $changed(so_pin.dout);
   endsequence
   property p_one_hot;
      $onehot(tap_sel[0]) && $onehot(tap_sel[1]);
   endproperty
   a_one_hot: assert property (p_one_hot) else $error("tap select not one-hot");
   property p_idle_oe;
      s_idle8 |-> !so_pin.oe;
   endproperty
   a_idle_oe: assert property (p_idle_oe) else $error("output driven while idle");
   property p_rose_oe;
      $rose(so_pin.oe) |-> !spi_pins.cs_n;
   endproperty
   a_rose_oe: assert property (p_rose_oe) else $error("output enabled unselected");
   property p_dout_edge;
      s_shift |-> !spi_pins.sck;
   endproperty
   a_dout_edge: assert property (p_dout_edge) else $error("output bit moved on high");
   property p_busy_wp;
      $rose(nv_busy) |-> write_protect_n;
   endproperty
   a_busy_wp: assert property (p_busy_wp) else $error("write under protect");
   property p_busy_cs;
      $rose(nv_busy) |-> !spi_pins.cs_n;
   endproperty
   a_busy_cs: assert property (p_busy_cs) else $error("write started unselected");
   property p_busy_max;
      busy_cnt_ff <= NV_WRITE_CYCLES;
   endproperty
   a_busy_max: assert property (p_busy_max) else $error("write runs too long");
   property p_busy_len;
      $fell(nv_busy) |-> busy_cnt_ff == NV_WRITE_CYCLES;
   endproperty
   a_busy_len: assert property (p_busy_len) else $error("write length wrong");
   property p_tap_stable;
      s_idle8 ##1 s_idle8 |-> $stable(tap_sel);
   endproperty
   a_tap_stable: assert property (p_tap_stable) else $error("wiper moved idle");
endmodule
bind dpot_serial_core dpot_serial_asserts #(.NV_WRITE_CYCLES(NV_WRITE_CYCLES)) chk (
   .clk(clk), .nrst(nrst), .spi_pins(spi_pins), .so_pin(so_pin),
   .write_protect_n(write_protect_n), .nv_busy(nv_busy), .tap_sel(tap_sel));
`default_nettype wire

// [tb/host_model.sv]
// serial bus master model driving the pot's link pins
`default_nettype none
module host_model (
   // clock
   input wire logic clk,
   // link
   output var dpot_pkg::spi_pins_t pins,
   input wire dpot_pkg::so_pin_t so_pin
);
   timeunit 1ns;
   timeprecision 100ps;
   logic last_ff;
   initial begin
      pins = '{cs_n: 1'b0, sck: 1'b0, si: 1'b0, hold_n: 1'b1};
      last_ff = 1'b0;
   end
   // 48 ns bit time; the clock is parked low between bits and frames
   task automatic pulse(input logic b, output logic r);
      pins.si = b;
      #24;
      r = so_pin.oe ? so_pin.dout : ~last_ff;
      last_ff = r;
      pins.sck = 1'b1;
      #24;
      pins.sck = 1'b0;
   endtask
   task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
      for (int i = 7; i >= 0; i--) begin
         pulse(tx[i], rx[i]);
      end
   endtask
   task automatic start();
      @(posedge clk);
      #1 pins.cs_n = 1'b0;
   endtask
   task automatic stop();
      #24 pins.cs_n = 1'b1;
      repeat (40) @(posedge clk);
      #1;
   endtask
   // stray pulses under hold must leave the sequence where it was
   task automatic pause(input int n);
      logic r;
      // let the last clock fall land before pausing, a read needs that edge
      #24 pins.hold_n = 1'b0;
      for (int i = 0; i < n; i++) begin
         pulse(1'b1, r);
      end
      #24 pins.hold_n = 1'b1;
   endtask
endmodule
`default_nettype wire

// [tb/tb_top.sv]
// self-checking bench for the dual pot serial core
`default_nettype none
`include "dpot_regs.svh"
module tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   localparam logic [3:0] TYPE_ID = 4'h6; // arbitrary value
   localparam logic [7:0] INIT = 8'h3c;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic ahi = 1'b0;
   logic alo = 1'b0;
   logic wp_n = 1'b1;
   logic busy;
   logic [1:0][255:0] tap;
   logic [7:0] id_byte;
   logic [7:0] nv_busy_flag [2];
   logic [7:0] slot [2][4];
   dpot_pkg::spi_pins_t pins;
   dpot_pkg::so_pin_t so;
   int error_cnt = 0;
   int total_checks = 0;
   always #2 clk = ~clk;
   host_model host (.clk(clk), .pins(pins), .so_pin(so));
   // long write time so a status read can still see it running
   dpot_serial_core #(.NV_WRITE_CYCLES(400), .TYPE_CODE(TYPE_ID), .SLOT_INIT(INIT)) dut (
      .clk(clk), .nrst(nrst), .spi_pins(pins), .so_pin(so), .addr_pin_hi(ahi),
      .addr_pin_lo(alo), .write_protect_n(wp_n), .nv_busy(busy), .tap_sel(tap));
   task automatic stop_test();
      $display("checks %0d mismatches %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task automatic chk8(input logic [7:0] e, input logic [7:0] g);
      total_checks++;
      if (g !== e) begin
         error_cnt++;
         $display("[FAIL] t=%0t exp=%h got=%h", $time, e, g);
      end
   endtask
   task automatic chk_tap(input int p);
      logic [255:0] e;
      e = 256'h1 << nv_busy_flag[p];
      total_checks++;
      if (tap[p] !== e) begin
         error_cnt++;
         $display("[FAIL] t=%0t exp=%h got=%h", $time, e, tap[p]);
      end
   endtask
   task automatic cmd(input logic [3:0] op, input logic [1:0] s, input logic p, input int n,
         input logic [7:0] d, input logic hp, output logic [7:0] rx);
      host.start();
      host.xfer(id_byte, rx);
      host.xfer({op, s, 1'b0, p}, rx);
      if (hp) begin
         host.pause(3);
      end
      if (n > 2) begin
         host.xfer(d, rx);
      end
      host.stop();
   endtask
   task automatic rd_wip(input int p);
      logic [7:0] r;
      cmd(`OP_RD_WIPER, 2'h0, 1'(p), 3, 8'h00, 1'b0, r);
      chk8(nv_busy_flag[p], r);
      chk_tap(p);
   endtask
   task automatic rd_slot(input int p, input int s);
      logic [7:0] r;
      cmd(`OP_RD_SLOT, 2'(s), 1'(p), 3, 8'h00, 1'b0, r);
      chk8(slot[p][s], r);
   endtask
   task automatic rd_stat(input logic e);
      logic [7:0] r;
      cmd(`OP_RD_STATUS, 2'h0, 1'b0, 3, 8'h00, 1'b0, r);
      chk8({7'h00, e}, r);
   endtask
   task automatic wait_idle();
      for (int i = 0; i < 1000 && busy !== 1'b0; i++) begin
         @(posedge clk);
      end
      #1;
   endtask
   function automatic logic [7:0] step_exp(input logic [7:0] w, input logic [7:0] b);
      for (int i = 7; i >= 0; i--) begin
         if (b[i]) begin
            w = (w == 8'hff) ? w : w + 8'h01;
         end else begin
            w = (w == 8'h00) ? w : w - 8'h01;
         end
      end
      return w;
   endfunction
   initial begin
      #400000;
      error_cnt++;
      stop_test();
   end
   initial begin
      logic [7:0] r;
      logic [7:0] d;
      logic [7:0] b;
      d = 8'($urandom(73667));
      ahi = 1'($urandom);
      alo = 1'($urandom);
      repeat (2) @(posedge clk);
      #1 nrst = 1'b1;
      repeat (20) @(posedge clk);
      #1;
      id_byte = {TYPE_ID, 2'b00, ahi, alo};
      // select has not fallen since power-up, so this whole write must be ignored
      host.xfer(id_byte, r);
      host.xfer({`OP_WR_WIPER, 4'h0}, r);
      host.xfer(~INIT, r);
      host.stop();
      for (int p = 0; p < 2; p++) begin
         nv_busy_flag[p] = INIT;
         for (int s = 0; s < 4; s++) begin
            slot[p][s] = INIT;
         end
         rd_wip(p);
      end
      $display("test power_up done");
      for (int k = 0; k < 2; k++) begin
         id_byte = k ? {TYPE_ID, 2'b00, ~ahi, alo} : {~TYPE_ID, 2'b00, ahi, alo};
         cmd(`OP_WR_WIPER, 2'h0, 1'b0, 3, ~INIT, 1'b0, r);
      end
      id_byte = {TYPE_ID, 2'b00, ahi, alo};
      rd_wip(0);
      $display("test bad_id done");
      for (int i = 0; i < 4; i++) begin
         d = 8'($urandom);
         cmd(`OP_WR_WIPER, 2'h0, i[0], 3, d, i == 3, r);
         nv_busy_flag[i % 2] = d;
         rd_wip(i % 2);
      end
      $display("test wiper_rw done");
      for (int i = 0; i < 8; i++) begin
         d = 8'($urandom);
         cmd(`OP_WR_SLOT, i[1:0], i[2], 3, d, 1'b0, r);
         slot[i / 4][i % 4] = d;
         rd_stat(1'b1);
         wait_idle();
         rd_stat(1'b0);
      end
      for (int i = 0; i < 8; i++) begin
         rd_slot(i / 4, i % 4);
      end
      $display("test slot_rw done");
      wp_n = 1'b0;
      cmd(`OP_WR_SLOT, 2'h1, 1'b0, 3, ~slot[0][1], 1'b0, r);
      rd_stat(1'b0);
      cmd(`OP_WIPER_TO_SLOT, 2'h2, 1'b1, 2, 8'h00, 1'b0, r);
      rd_stat(1'b0);
      wp_n = 1'b1;
      rd_slot(0, 1);
      rd_slot(1, 2);
      $display("test protect done");
      cmd(`OP_SLOT_TO_WIPER, 2'h2, 1'b1, 2, 8'h00, 1'b0, r);
      nv_busy_flag[1] = slot[1][2];
      rd_wip(1);
      cmd(`OP_WIPER_TO_SLOT, 2'h3, 1'b0, 2, 8'h00, 1'b0, r);
      slot[0][3] = nv_busy_flag[0];
      wait_idle();
      rd_slot(0, 3);
      cmd(`OP_GLB_SLOT_TO_WIPER, 2'h1, 1'b0, 2, 8'h00, 1'b0, r);
      cmd(`OP_GLB_WIPER_TO_SLOT, 2'h0, 1'b0, 2, 8'h00, 1'b0, r);
      wait_idle();
      for (int p = 0; p < 2; p++) begin
         nv_busy_flag[p] = slot[p][1];
         slot[p][0] = nv_busy_flag[p];
         rd_wip(p);
         rd_slot(p, 0);
      end
      $display("test copy done");
      for (int k = 0; k < 3; k++) begin
         d = k == 0 ? 8'hfe : k == 1 ? 8'h03 : 8'($urandom);
         b = k == 0 ? 8'hff : k == 1 ? 8'h00 : 8'($urandom);
         cmd(`OP_WR_WIPER, 2'h0, k[0], 3, d, 1'b0, r);
         cmd(`OP_STEP, 2'h0, k[0], 3, b, 1'b0, r);
         // clocks while deselected must not step the wiper any further
         host.xfer(~b, r);
         nv_busy_flag[k % 2] = step_exp(d, b);
         rd_wip(k % 2);
      end
      $display("test step done");
      stop_test();
   end
endmodule
`default_nettype wire
